// *** src/mul_logic_defines.svh ***
/*
 * Timing constants for the multiply and logic-class pipeline sequencer.
 * Assumes inclusion by the sequencer module only.
 */
// Summary of operation
// - Long multiply-accumulate: fetch, decode, execute, two memory, three multiplier-busy stages.
// - After its last memory stage the multiplier stays busy three cycles.
// - Decode of the follower to a multiply-accumulate waits one slot.
// - Its memory stages share slots with colliding fetches, memory first.
// - Without multiplier use by the follower it acts as five stages.
// - Multiplier user behind a busy multiplier waits for multiplier contention.
// - Word multiplies: four stages then two multiplier-busy cycles.
// - Word multiply followed by non-multiplier instruction causes no stall.
// - Double-length and long multiplies: two memory stages, three busy cycles.
// - Double-length: follower decode waits one slot; memory shares with fetch.
// - Logic ops: five stages, idle hold, result written in writeback.
// - Register test writes status in writeback; status reads in the next two decode slots contend.
// - Byte memory logic: six stages, next decode stalls two slots.
// - Memory byte test: seven stages, flag written in writeback, status contention.
// - Atomic test-and-set: three memory stages, flag in writeback, contention.
// - Extended variant: decode after test-and-set held three slots.
// - Extended variant: long multiply pipelines have nine stages.
`ifndef MUL_LOGIC_DEFINES_SVH
`define MUL_LOGIC_DEFINES_SVH
`define MAC_BUSY_CYCLES   3'h3
`define WORD_BUSY_CYCLES  3'h2
`define DSP_EXTRA_BUSY    3'h1
`define MEMLOGIC_STALL    3'h2
`define TAS_DSP_STALL     3'h3
`define MAC_STALL         3'h1
`define SR_HAZARD_DEPTH   2'h2
`endif

// *** src/mul_logic_pkg.sv ***
/*
 * Types for the multiply and logic-class pipeline sequencer.
 * Assumes the defines header is compiled first.
 */
package mul_logic_pkg;
	typedef enum logic [3:0] {
		OP_OTHER       = 4'h0,
		OP_MAC_LONG    = 4'h1,
		OP_WORD_MUL    = 4'h2,
		OP_DOUBLE_MUL  = 4'h3,
		OP_LOGIC       = 4'h4,
		OP_REG_TEST    = 4'h5,
		OP_MEM_LOGIC   = 4'h6,
		OP_MEM_TEST    = 4'h7,
		OP_ATOMIC_TAS  = 4'h8
	} op_class_type;

	// Gray along decode -> operate -> memory -> operate2 -> memory2 -> hold -> writeback
	typedef enum logic [2:0] {
		ST_DECODE   = 3'b000,
		ST_OPERATE  = 3'b001,
		ST_MEM      = 3'b011,
		ST_OPERATE2 = 3'b010,
		ST_MEM2     = 3'b110,
		ST_HOLD     = 3'b111,
		ST_WB       = 3'b101
	} stage_type;

	typedef struct packed {
		logic         valid;
		op_class_type op;
		logic         uses_mul;
		logic         reads_sr;
	} instr_type;

	typedef struct packed {
		logic mem_req;
		logic fetch_grant;
		logic mul_start;
		logic reg_write;
		logic sr_write;
	} stage_out_type;

	typedef struct packed {
		stage_type    stage;
		op_class_type op;
		logic [1:0]   mem_left;
		logic [2:0]   busy;
		logic [2:0]   stall;
		logic [1:0]   sr_age;
		logic         sr_pend;
	} seq_state_type;
endpackage : mul_logic_pkg

// *** src/mul_logic_seq.sv ***
/*
 * Sequencer for multiply, multiply-accumulate and logic instruction classes.
 * Assumes the fetch unit offers one decoded instruction per slot and holds
 * it while o_decode_ready is low; inputs are synchronous to i_clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none
`include "mul_logic_defines.svh"
module mul_logic_seq #(
	parameter bit DSP_VARIANT = 1'b0
) (
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_rst,
	input  wire mul_logic_pkg::instr_type  i_instr,
	input  wire logic                      i_fetch_req,
	output logic                           o_decode_ready,
	output mul_logic_pkg::stage_out_type   o_stage,
	output logic                           o_mul_busy,
	output logic                           o_sr_stall
);
	import mul_logic_pkg::*;

	seq_state_type st_r;
	seq_state_type st_nxt;
	logic          idle;
	logic          mul_block;
	logic          sr_block;
	logic          in_mem;
	logic [2:0]    mac_busy;

	if (DSP_VARIANT !== 1'b0 && DSP_VARIANT !== 1'b1) begin : g_bad_variant
		$error("DSP_VARIANT must be 0 or 1");
	end

	assign mac_busy  = DSP_VARIANT ? `MAC_BUSY_CYCLES + `DSP_EXTRA_BUSY : `MAC_BUSY_CYCLES;
	assign idle      = (st_r.stage == ST_DECODE) && (st_r.stall == 3'h0);
	assign mul_block = i_instr.valid && i_instr.uses_mul && (st_r.busy != 3'h0);
	assign sr_block  = i_instr.valid && i_instr.reads_sr && st_r.sr_pend;
	assign in_mem    = (st_r.stage == ST_MEM) || (st_r.stage == ST_MEM2);
	assign o_decode_ready = idle && !mul_block && !sr_block;
	assign o_sr_stall     = sr_block;
	assign o_mul_busy     = (st_r.busy != 3'h0);

	always_comb begin
		st_nxt = st_r;
		o_stage = '0;
		// Busy count runs down every cycle regardless of slot use
		if (st_r.busy != 3'h0) begin
			st_nxt.busy = st_r.busy - 3'h1;
		end
		// Decode hold counts only slots spent back in decode
		if (st_r.stage == ST_DECODE && st_r.stall != 3'h0) begin
			st_nxt.stall = st_r.stall - 3'h1;
		end
		// Status write blocks readers for two decode slots
		// Counted by slot, not by take, so a blocked reader cannot hang
		if (st_r.sr_pend && st_r.stage == ST_DECODE) begin
			if (st_r.sr_age == 2'h1) begin
				st_nxt.sr_pend = 1'b0;
			end
			st_nxt.sr_age = st_r.sr_age - 2'h1;
		end
		// Memory wins the slot; fetch is granted when no access runs
		o_stage.fetch_grant = i_fetch_req && !in_mem;
		case (st_r.stage)
			ST_DECODE: begin
				if (o_decode_ready && i_instr.valid) begin
					st_nxt.op    = i_instr.op;
					st_nxt.stage = ST_OPERATE;
				end
			end
			ST_OPERATE: begin
				case (st_r.op)
					OP_MAC_LONG, OP_DOUBLE_MUL: begin
						st_nxt.stage    = ST_MEM;
						st_nxt.mem_left = 2'h1;
						st_nxt.stall    = `MAC_STALL;
					end
					OP_WORD_MUL, OP_MEM_LOGIC, OP_MEM_TEST: begin
						st_nxt.stage    = ST_MEM;
						st_nxt.mem_left = 2'h0;
						if (st_r.op == OP_MEM_LOGIC) begin
							st_nxt.stall = `MEMLOGIC_STALL;
						end
					end
					OP_ATOMIC_TAS: begin
						st_nxt.stage    = ST_MEM;
						st_nxt.mem_left = 2'h2;
						if (DSP_VARIANT) begin
							st_nxt.stall = `TAS_DSP_STALL;
						end
					end
					OP_LOGIC, OP_REG_TEST: begin
						st_nxt.stage = ST_HOLD;
					end
					default: begin
						st_nxt.stage = ST_DECODE;
					end
				endcase
			end
			ST_MEM: begin
				o_stage.mem_req = 1'b1;
				if (st_r.mem_left != 2'h0) begin
					st_nxt.mem_left = st_r.mem_left - 2'h1;
					if (st_r.mem_left == 2'h1 && st_r.op != OP_ATOMIC_TAS) begin
						st_nxt.stage = ST_MEM2;
					end
				end else begin
					case (st_r.op)
						OP_WORD_MUL: begin
							o_stage.mul_start = 1'b1;
							st_nxt.busy  = `WORD_BUSY_CYCLES;
							st_nxt.stage = ST_DECODE;
						end
						OP_MEM_LOGIC, OP_MEM_TEST: begin
							st_nxt.stage = ST_OPERATE2;
						end
						OP_ATOMIC_TAS: begin
							st_nxt.stage = ST_WB;
						end
						default: begin
							st_nxt.stage = ST_DECODE;
						end
					endcase
				end
			end
			ST_OPERATE2: begin
				st_nxt.stage = ST_MEM2;
			end
			ST_MEM2: begin
				o_stage.mem_req = 1'b1;
				case (st_r.op)
					OP_MAC_LONG, OP_DOUBLE_MUL: begin
						o_stage.mul_start = 1'b1;
						st_nxt.busy  = mac_busy;
						st_nxt.stage = ST_DECODE;
					end
					OP_MEM_TEST: begin
						st_nxt.stage = ST_WB;
					end
					default: begin
						st_nxt.stage = ST_DECODE;
					end
				endcase
			end
			ST_HOLD: begin
				st_nxt.stage = ST_WB;
			end
			ST_WB: begin
				if (st_r.op == OP_LOGIC) begin
					o_stage.reg_write = 1'b1;
				end else begin
					o_stage.sr_write = 1'b1;
					st_nxt.sr_pend   = 1'b1;
					st_nxt.sr_age    = `SR_HAZARD_DEPTH;
				end
				st_nxt.stage = ST_DECODE;
			end
			default: begin
				st_nxt.stage = ST_DECODE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : mul_logic_seq
`default_nettype wire

// *** tb/mul_logic_seq_monitor.sv ***
/* Port checker for the sequencer.
 * Assumes a bind onto mul_logic_seq. */
`timescale 1ns/10ps
`default_nettype none
module mul_logic_seq_monitor #(
	parameter bit DSP_VARIANT = 1'b0
) (
	input wire logic                         i_clk_sys,
	input wire logic                         i_rst,
	input wire mul_logic_pkg::instr_type     i_instr,
	input wire logic                         i_fetch_req,
	input wire logic                         o_decode_ready,
	input wire mul_logic_pkg::stage_out_type o_stage,
	input wire logic                         o_mul_busy,
	input wire logic                         o_sr_stall
);
	import mul_logic_pkg::*;
	wire logic tk = i_instr.valid && o_decode_ready;
	wire logic mq = o_stage.mem_req;
	wire logic mb = o_mul_busy;
	wire logic tk_long = tk && (i_instr.op == OP_MAC_LONG || i_instr.op == OP_DOUBLE_MUL);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	a_word_busy_two: assert property (tk && i_instr.op == OP_WORD_MUL
		|-> ##2 mq && o_stage.mul_start ##1 mb [*2] ##1 !mb) else $error("word busy");
	a_mac_busy_three: assert property (tk && i_instr.op == OP_MAC_LONG && !DSP_VARIANT
		|-> ##2 mq ##1 mq && o_stage.mul_start ##1 mb [*3] ##1 !mb) else $error("mac busy");
	a_mem_wins: assert property (mq |-> !o_stage.fetch_grant) else $error("fetch clash");
	a_fetch_slot: assert property (i_fetch_req && !mq |-> o_stage.fetch_grant)
		else $error("fetch lost");
	a_mul_user_wait: assert property (mb && i_instr.valid && i_instr.uses_mul
		|-> !o_decode_ready) else $error("mul user taken");
	a_logic_wb: assert property (tk && i_instr.op == OP_LOGIC
		|=> !o_stage.reg_write [*2] ##1 o_stage.reg_write) else $error("logic wb");
	a_memlogic_order: assert property (tk && i_instr.op == OP_MEM_LOGIC
		|-> ##2 mq ##1 !mq ##1 mq ##1 !o_decode_ready [*2]) else $error("mem logic");
	a_tas_order: assert property (tk && i_instr.op == OP_ATOMIC_TAS
		|-> ##2 mq [*3] ##1 o_stage.sr_write) else $error("tas order");
	a_mac_busy_four: assert property (tk && i_instr.op == OP_MAC_LONG && DSP_VARIANT
		|-> ##2 mq ##1 (mq && o_stage.mul_start) ##1 mb [*4] ##1 !mb) else $error("dsp mac busy");
	a_mac_hold: assert property (tk_long
		|-> ##4 !o_decode_ready) else $error("mac hold");
	a_tas_hold: assert property (tk && i_instr.op == OP_ATOMIC_TAS && DSP_VARIANT
		|-> ##6 !o_decode_ready [*3]) else $error("tas hold");
	a_sr_hold: assert property (o_stage.sr_write ##1 (i_instr.valid && i_instr.reads_sr)
		|-> o_sr_stall [*2] ##1 !o_sr_stall) else $error("sr hold");
	c_mac: cover property (tk && i_instr.op == OP_MAC_LONG);
	c_clash: cover property (mq && i_fetch_req);
	c_sr: cover property (o_sr_stall);
	c_dsp_tas: cover property (tk && i_instr.op == OP_ATOMIC_TAS && DSP_VARIANT);
endmodule : mul_logic_seq_monitor
`default_nettype wire

// *** tb/fetch_bus_model.sv ***
/* Fetch side: asks for a slot, holds it until granted.
 * Assumes grant from the sequencer. */
`timescale 1ns/10ps
`default_nettype none
module fetch_bus_model (
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	input  wire logic i_grant,
	output logic      o_fetch_req
);
	always_ff @(posedge i_clk_sys) begin
		if (i_rst)
			o_fetch_req <= 1'b0;
		else
			o_fetch_req <= !o_fetch_req || !i_grant;
	end
endmodule : fetch_bus_model
`default_nettype wire

// *** tb/cpu_mul_logic_pipeline_timing_tb.sv ***
/* Bench for the sequencer: slot gaps between instruction pairs.
 * Assumes package, fetch model and monitor compiled first. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; $display("BAD %0t gap", $time); end end
module cpu_mul_logic_pipeline_timing_tb;
	import mul_logic_pkg::*;
	logic          i_clk_sys = 1'b0;
	logic          i_rst = 1'b1;
	instr_type     i_instr = '0;
	instr_type     instr_dsp = '0;
	logic          fetch_req, ready, busy, sr_stall;
	logic          ready_dsp, busy_dsp, sr_stall_dsp;
	stage_out_type stage;
	stage_out_type stage_dsp;
	bit            use_dsp = 1'b0;
	int            cyc = 0, fails = 0, checks = 0;
	initial forever #2 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) cyc <= cyc + 1;
	mul_logic_seq #(.DSP_VARIANT(1'b0)) u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_instr(i_instr), .i_fetch_req(fetch_req), .o_decode_ready(ready),
		.o_stage(stage), .o_mul_busy(busy), .o_sr_stall(sr_stall));
	mul_logic_seq #(.DSP_VARIANT(1'b1)) u_dut_dsp (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_instr(instr_dsp), .i_fetch_req(fetch_req), .o_decode_ready(ready_dsp),
		.o_stage(stage_dsp), .o_mul_busy(busy_dsp), .o_sr_stall(sr_stall_dsp));
	fetch_bus_model u_fetch (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_grant(stage.fetch_grant), .o_fetch_req(fetch_req));
	task complete_run;
		$display("fails=%0d checks=%0d", fails, checks);
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : complete_run
	task issue(op_class_type op, logic um, logic rs);
		int n;
		if (use_dsp) begin
			instr_dsp <= '{1'b1, op, um, rs};
		end else begin
			i_instr <= '{1'b1, op, um, rs};
		end
		n = 0;
		do begin
			@(negedge i_clk_sys);
			n++;
		end while ((use_dsp ? ready_dsp : ready) !== 1'b1 && n < 40);
		if ((use_dsp ? ready_dsp : ready) !== 1'b1) begin
			fails++;
			$display("BAD %0t timeout", $time);
			complete_run;
		end
		@(posedge i_clk_sys);
	endtask : issue
	// Zero expected gap means the follower must be held past four slots
	task gap(op_class_type a, op_class_type b, logic um, logic rs, int e);
		int t;
		issue(a, a inside {OP_MAC_LONG, OP_WORD_MUL, OP_DOUBLE_MUL}, 1'b0);
		t = cyc;
		issue(b, um, rs);
		i_instr.valid <= 1'b0;
		instr_dsp.valid <= 1'b0;
		`CHK(e ? cyc - t == e : cyc - t > 4, 1'b1)
		repeat (12) @(posedge i_clk_sys);
	endtask : gap
	task t_word;
		gap(OP_WORD_MUL, OP_LOGIC, 1'b0, 1'b0, 3);
		gap(OP_WORD_MUL, OP_WORD_MUL, 1'b1, 1'b0, 5);
	endtask : t_word
	task t_mac;
		gap(OP_MAC_LONG, OP_LOGIC, 1'b0, 1'b0, 5);
		gap(OP_MAC_LONG, OP_WORD_MUL, 1'b1, 1'b0, 7);
	endtask : t_mac
	task t_dbl;
		gap(OP_DOUBLE_MUL, OP_LOGIC, 1'b0, 1'b0, 5);
		gap(OP_DOUBLE_MUL, OP_DOUBLE_MUL, 1'b1, 1'b0, 7);
	endtask : t_dbl
	task t_logic;
		gap(OP_LOGIC, OP_LOGIC, 1'b0, 1'b0, 4);
		gap(OP_REG_TEST, OP_LOGIC, 1'b0, 1'b1, 0);
	endtask : t_logic
	task t_mem;
		gap(OP_MEM_LOGIC, OP_LOGIC, 1'b0, 1'b0, 7);
		gap(OP_MEM_TEST, OP_LOGIC, 1'b0, 1'b0, 6);
		gap(OP_ATOMIC_TAS, OP_LOGIC, 1'b0, 1'b0, 6);
	endtask : t_mem
	task t_dsp;
		use_dsp = 1'b1;
		gap(OP_MAC_LONG, OP_WORD_MUL, 1'b1, 1'b0, 8);
		gap(OP_ATOMIC_TAS, OP_LOGIC, 1'b0, 1'b0, 9);
		use_dsp = 1'b0;
	endtask : t_dsp
	initial begin
		repeat (16) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		t_word;
		t_mac;
		t_dbl;
		t_logic;
		t_mem;
		t_dsp;
		complete_run;
	end
endmodule : cpu_mul_logic_pipeline_timing_tb
bind mul_logic_seq mul_logic_seq_monitor #(.DSP_VARIANT(DSP_VARIANT)) u_mon (.i_clk_sys,
	.i_rst, .i_instr, .i_fetch_req, .o_decode_ready, .o_stage, .o_mul_busy, .o_sr_stall);
`default_nettype wire
